// ===== dcb_transfer_controller.sv
// Top of the DMA cycle control and bus drive block: AXI4-Lite registers,
// interrupt, sequencer instance and the registered pin output stage.
// Assumes all pin inputs are synchronous to aclk and the address and word
// counters sit outside, driven by count_pulse and counter_clear.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module dcb_transfer_controller (
  // Clock, reset, clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // CPU register access pins
  input wire logic cpu_cs_n,
  input wire logic cpu_iord_n,
  input wire logic register_select_bit,
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Memory address and strobes
  input wire logic [22:0] addr_in,
  output logic [22:0] addr_out,
  output logic addr_oe_n,
  output logic strobe_oe_n,
  output logic mem_read,
  output logic mem_write,
  output logic io_read,
  output logic io_write,
  // Bus and transfer handshakes
  output logic hold_request,
  input wire logic hold_ack,
  input wire logic transfer_request,
  output logic transfer_ack,
  // Counter control
  output logic count_pulse,
  output logic counter_clear,
  input wire logic count_zero,
  // Interrupt
  output logic irq
);

  // Register state.
  logic [4:0] ctrl_q;
  logic [4:0] ctrl_d;
  logic [1:0] int_sts_q;
  logic [1:0] int_sts_d;
  logic [1:0] int_mask_q;
  logic [1:0] int_mask_d;
  logic irq_q;
  logic counter_clear_q;

  // Write channel state.
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Read channel state.
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Pin output stage.
  logic [15:0] data_out_q;
  logic data_oe_n_q;
  logic [22:0] addr_out_q;

  // Sequencer.
  logic [dcb_pkg::SO_W-1:0] seq_out;
  dcb_pkg::dcb_state_t seq_state;

  function automatic logic is_mapped(input logic [3:0] a);
    return (a == dcb_pkg::OFS_CTRL) || (a == dcb_pkg::OFS_STATUS) ||
           (a == dcb_pkg::OFS_INT_STS) || (a == dcb_pkg::OFS_INT_MASK);
  endfunction : is_mapped

  dcb_cycle_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(ctrl_q[dcb_pkg::CTRL_ENABLE]),
    .int_enable(ctrl_q[dcb_pkg::CTRL_INT_EN]),
    .burst(ctrl_q[dcb_pkg::CTRL_BURST]),
    .direction(ctrl_q[dcb_pkg::CTRL_DIR]),
    .transfer_request(transfer_request),
    .hold_ack(hold_ack),
    .count_zero(count_zero),
    .seq_out(seq_out),
    .state(seq_state)
  );

  // Write channel: address and data are taken in either order, answer follows both.
  wire aw_take = awvalid && awready_q;
  wire w_take = wvalid && wready_q;
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
  wire aw_full_d = aw_take || (aw_full_q && !wr_fire);
  wire w_full_d = w_take || (w_full_q && !wr_fire);
  wire bvalid_d = wr_fire || (bvalid_q && !bready);
  wire wr_mapped = is_mapped(aw_addr_q);
  wire wr_lane0 = wr_fire && w_strb_q[0];
  wire wr_ctrl = wr_lane0 && (aw_addr_q == dcb_pkg::OFS_CTRL);
  wire wr_int_sts = wr_lane0 && (aw_addr_q == dcb_pkg::OFS_INT_STS);
  wire wr_int_mask = wr_lane0 && (aw_addr_q == dcb_pkg::OFS_INT_MASK);

  // Read channel: one read at a time, data held until rready.
  wire ar_take = arvalid && arready_q;
  wire rvalid_d = ar_take || (rvalid_q && !rready);

  // Sequencer pulses and the interrupt events they raise.
  wire seq_clrenb = seq_out[dcb_pkg::SO_CLRENB];
  wire seq_setint = seq_out[dcb_pkg::SO_SETINT];
  wire [1:0] int_event = {seq_out[dcb_pkg::SO_COUNT], seq_setint};

  // The clear-enable pulse wins over a simultaneous software write of the enable bit,
  // because the sequencer has just finished the terminal transfer.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = w_data_q[4:0];
    end
    ctrl_d[dcb_pkg::CTRL_CLR_CNT] = 1'b0;
    if (seq_clrenb) begin
      ctrl_d[dcb_pkg::CTRL_ENABLE] = 1'b0;
    end
  end

  // Sticky status: a new event wins over a write-one clear in the same cycle.
  assign int_sts_d = (int_sts_q & ~(wr_int_sts ? w_data_q[1:0] : 2'h0)) | int_event;
  assign int_mask_d = wr_int_mask ? w_data_q[1:0] : int_mask_q;

  wire [31:0] reg_status = {20'h00000, seq_state, 3'h0, count_zero,
                            transfer_request, hold_ack, seq_out[dcb_pkg::SO_OE],
                            seq_out[dcb_pkg::SO_HREQ]};
  wire [31:0] rd_value =
      (araddr == dcb_pkg::OFS_CTRL) ? {27'h0000000, ctrl_q} :
      (araddr == dcb_pkg::OFS_STATUS) ? reg_status :
      (araddr == dcb_pkg::OFS_INT_STS) ? {30'h00000000, int_sts_q} :
      (araddr == dcb_pkg::OFS_INT_MASK) ? {30'h00000000, int_mask_q} : 32'h00000000;

  // Pin read path: decoder enable and the two-way word selection.
  wire register_read_enable = !cpu_cs_n && !cpu_iord_n;
  wire [15:0] pin_status_word = {2'h0, ctrl_q[dcb_pkg::CTRL_DIR], 1'b0,
                                 ctrl_q[dcb_pkg::CTRL_BURST], 1'b0,
                                 ctrl_q[dcb_pkg::CTRL_INT_EN],
                                 ctrl_q[dcb_pkg::CTRL_ENABLE], 1'b0, addr_in[22:16]};
  wire [15:0] pin_word = register_select_bit ? pin_status_word : addr_in[15:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= dcb_pkg::RESP_OKAY;
    end else if (ce) begin
      awready_q <= !aw_full_d;
      wready_q <= !w_full_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      bvalid_q <= bvalid_d;
      if (wr_fire) bresp_q <= wr_mapped ? dcb_pkg::RESP_OKAY : dcb_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= dcb_pkg::RESP_OKAY;
    end else if (ce) begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_value;
        rresp_q <= is_mapped(araddr) ? dcb_pkg::RESP_OKAY : dcb_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dcb_pkg::CTRL_RESET;
      int_sts_q <= dcb_pkg::INT_RESET;
      int_mask_q <= dcb_pkg::INT_RESET;
      irq_q <= 1'b0;
      counter_clear_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      int_sts_q <= int_sts_d;
      int_mask_q <= int_mask_d;
      irq_q <= |(int_sts_d & int_mask_d);
      // Clear-counter bit self-clears; the sequencer also clears at terminal count.
      counter_clear_q <= (wr_ctrl && w_data_q[dcb_pkg::CTRL_CLR_CNT]) || seq_clrenb;
    end
  end

  // Data pins float unless the CPU is reading a register; address follows the counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out_q <= 16'h0000;
      data_oe_n_q <= 1'b1;
      addr_out_q <= 23'h000000;
    end else if (ce) begin
      data_out_q <= pin_word;
      data_oe_n_q <= !register_read_enable;
      addr_out_q <= addr_in;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  assign data_out = data_out_q;
  assign data_oe_n = data_oe_n_q;
  assign addr_out = addr_out_q;

  // One registered enable bit drives both the address and strobe drivers.
  assign addr_oe_n = !seq_out[dcb_pkg::SO_OE];
  assign strobe_oe_n = !seq_out[dcb_pkg::SO_OE];
  assign mem_read = seq_out[dcb_pkg::SO_MEMR];
  assign mem_write = seq_out[dcb_pkg::SO_MEMW];
  assign io_read = seq_out[dcb_pkg::SO_IORD];
  assign io_write = seq_out[dcb_pkg::SO_IOWR];
  assign hold_request = seq_out[dcb_pkg::SO_HREQ];
  assign transfer_ack = seq_out[dcb_pkg::SO_DACK];
  assign count_pulse = seq_out[dcb_pkg::SO_COUNT];
  assign counter_clear = counter_clear_q;
  assign irq = irq_q;

endmodule : dcb_transfer_controller

// ===== dcb_pkg.sv
// Shared constants and types of the DMA cycle control and bus drive block.
// Assumes a single 40 MHz clock domain and an AXI4-Lite register port.
package dcb_pkg;

  // Register byte offsets on the AXI4-Lite port.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_INT_STS = 4'h8;
  localparam logic [3:0] OFS_INT_MASK = 4'hC;

  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_INT_EN = 1;
  localparam int CTRL_CLR_CNT = 2;
  localparam int CTRL_BURST = 3;
  localparam int CTRL_DIR = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Interrupt status and mask fields.
  localparam int INT_TERMINAL = 0;
  localparam int INT_XFER_DONE = 1;
  localparam logic [1:0] INT_RESET = 2'h0;

  // Pin-side status word fields returned when the register select bit is 1.
  localparam int PIN_ST_ENABLE = 8;
  localparam int PIN_ST_INT_EN = 9;
  localparam int PIN_ST_BURST = 11;
  localparam int PIN_ST_DIR = 13;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer output vector bit positions.
  localparam int SO_HREQ = 0;
  localparam int SO_OE = 1;
  localparam int SO_DACK = 2;
  localparam int SO_MEMR = 3;
  localparam int SO_MEMW = 4;
  localparam int SO_IORD = 5;
  localparam int SO_IOWR = 6;
  localparam int SO_COUNT = 7;
  localparam int SO_SETINT = 8;
  localparam int SO_CLRENB = 9;
  localparam int SO_W = 10;
  localparam logic [SO_W-1:0] SO_RESET = 10'h000;

  // Gray-coded from idle along the memory path to end hold; the device path, ST_END to ST_DIR_SEL or ST_CLR_EN and the step back to idle are not.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HOLD_WAIT = 4'h1,
    ST_DIR_SEL = 4'h3,
    ST_MEM0 = 4'h2,
    ST_MEM1 = 4'h6,
    ST_MEM2 = 4'h7,
    ST_IO0 = 4'hF,
    ST_IO1 = 4'hE,
    ST_IO2 = 4'hA,
    ST_END = 4'h5,
    ST_SET_INT = 4'h4,
    ST_CLR_EN = 4'hC,
    ST_END_HOLD = 4'hD
  } dcb_state_t;

endpackage : dcb_pkg

// ===== dcb_cycle_sequencer.sv
// Cycle sequencer: hold handshake, transfer strobes, counter and interrupt pulses.
// Assumes synchronous inputs; every output except state is a bit of the registered output vector.
`timescale 1ns/1ps
module dcb_cycle_sequencer (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Configuration
  input wire logic enable,
  input wire logic int_enable,
  input wire logic burst,
  input wire logic direction,
  // Handshakes and counter status
  input wire logic transfer_request,
  input wire logic hold_ack,
  input wire logic count_zero,
  // Registered outputs
  output logic [dcb_pkg::SO_W-1:0] seq_out,
  output dcb_pkg::dcb_state_t state
);

  dcb_pkg::dcb_state_t state_q;
  dcb_pkg::dcb_state_t state_d;
  logic [dcb_pkg::SO_W-1:0] out_q;

  // Output pattern of each state; registered together with the state.
  function automatic logic [dcb_pkg::SO_W-1:0] outs_of(input dcb_pkg::dcb_state_t s);
    logic [dcb_pkg::SO_W-1:0] o;
    o = dcb_pkg::SO_RESET;
    unique case (s)
      dcb_pkg::ST_IDLE, dcb_pkg::ST_END_HOLD: o = dcb_pkg::SO_RESET;
      dcb_pkg::ST_HOLD_WAIT: o[dcb_pkg::SO_HREQ] = 1'b1;
      dcb_pkg::ST_DIR_SEL, dcb_pkg::ST_END: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_OE] = 1'b1;
      end
      dcb_pkg::ST_MEM0, dcb_pkg::ST_MEM1: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_OE] = 1'b1;
        o[dcb_pkg::SO_DACK] = 1'b1;
        o[dcb_pkg::SO_MEMR] = 1'b1;
        o[dcb_pkg::SO_IOWR] = (s == dcb_pkg::ST_MEM1);
      end
      dcb_pkg::ST_IO0, dcb_pkg::ST_IO1: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_OE] = 1'b1;
        o[dcb_pkg::SO_DACK] = 1'b1;
        o[dcb_pkg::SO_IORD] = 1'b1;
        o[dcb_pkg::SO_MEMW] = (s == dcb_pkg::ST_IO1);
      end
      dcb_pkg::ST_MEM2, dcb_pkg::ST_IO2: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_OE] = 1'b1;
        o[dcb_pkg::SO_COUNT] = 1'b1;
      end
      dcb_pkg::ST_SET_INT: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_SETINT] = 1'b1;
      end
      dcb_pkg::ST_CLR_EN: begin
        o[dcb_pkg::SO_HREQ] = 1'b1;
        o[dcb_pkg::SO_CLRENB] = 1'b1;
      end
      default: o = dcb_pkg::SO_RESET;
    endcase
    return o;
  endfunction : outs_of

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dcb_pkg::ST_IDLE:
        if (enable && transfer_request) state_d = dcb_pkg::ST_HOLD_WAIT;
      dcb_pkg::ST_HOLD_WAIT:
        if (hold_ack) state_d = dcb_pkg::ST_DIR_SEL;
      dcb_pkg::ST_DIR_SEL:
        state_d = direction ? dcb_pkg::ST_IO0 : dcb_pkg::ST_MEM0;
      dcb_pkg::ST_MEM0: state_d = dcb_pkg::ST_MEM1;
      dcb_pkg::ST_MEM1: state_d = dcb_pkg::ST_MEM2;
      dcb_pkg::ST_MEM2: state_d = dcb_pkg::ST_END;
      dcb_pkg::ST_IO0: state_d = dcb_pkg::ST_IO1;
      dcb_pkg::ST_IO1: state_d = dcb_pkg::ST_IO2;
      dcb_pkg::ST_IO2: state_d = dcb_pkg::ST_END;
      dcb_pkg::ST_END: begin
        if (!count_zero && burst && transfer_request) state_d = dcb_pkg::ST_DIR_SEL;
        else if (!count_zero) state_d = dcb_pkg::ST_END_HOLD;
        else if (int_enable) state_d = dcb_pkg::ST_SET_INT;
        else state_d = dcb_pkg::ST_CLR_EN;
      end
      dcb_pkg::ST_SET_INT: state_d = dcb_pkg::ST_CLR_EN;
      dcb_pkg::ST_CLR_EN: state_d = dcb_pkg::ST_END_HOLD;
      dcb_pkg::ST_END_HOLD:
        if (!hold_ack) state_d = dcb_pkg::ST_IDLE;
      // Unused codes recover to idle rather than lock up.
      default: state_d = dcb_pkg::ST_IDLE;
    endcase
  end

  // Outputs are flops loaded from the next state, so they change with the state bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= dcb_pkg::ST_IDLE;
      out_q <= dcb_pkg::SO_RESET;
    end else if (ce) begin
      state_q <= state_d;
      out_q <= outs_of(state_d);
    end
  end

  assign seq_out = out_q;
  assign state = state_q;

endmodule : dcb_cycle_sequencer

// ===== dcb_far_model.sv
// Far-side model: the CPU hold grant plus the external address and word counters.
// Assumes the block's clock and reset; the bench drives slow, load and load_words.
`timescale 1ns/1ps
module dcb_far_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic slow,
  input wire logic load,
  input wire logic [15:0] load_words,
  // Block side
  input wire logic hold_request,
  input wire logic count_pulse,
  input wire logic counter_clear,
  output logic hold_ack,
  output logic count_zero,
  output logic [22:0] addr_in
);
  logic [15:0] words_q;
  logic [2:0] wait_q;
  assign count_zero = (words_q == 16'h0000);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_ack <= 1'h0;
      wait_q <= 3'h0;
      words_q <= 16'h0000;
      addr_in <= 23'h00FFFE;
    end else begin
      // The grant follows the request and is taken back only after the request drops.
      if (hold_request != hold_ack) begin
        wait_q <= wait_q + 3'h1;
        if (wait_q == (slow ? 3'h5 : 3'h1)) begin
          hold_ack <= hold_request;
          wait_q <= 3'h0;
        end
      end else begin
        wait_q <= 3'h0;
      end
      if (load) begin
        words_q <= load_words;
      end else if (counter_clear) begin
        words_q <= 16'h0000;
      end else if (count_pulse && !count_zero) begin
        words_q <= words_q - 16'h0001;
      end
      if (count_pulse) begin
        addr_in <= addr_in + 23'h000001;
      end
    end
  end
endmodule : dcb_far_model

// ===== dcb_checker.sv
// Checker for the transfer controller's pin side, bound to its top module.
// Assumes one clock domain and the active-low synchronous reset.
`timescale 1ns/1ps
module dcb_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // CPU read pins
  input wire logic cpu_cs_n,
  input wire logic cpu_iord_n,
  input wire logic register_select_bit,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n,
  // Bus drive and handshakes
  input wire logic [22:0] addr_in,
  input wire logic addr_oe_n,
  input wire logic strobe_oe_n,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic hold_request,
  input wire logic hold_ack,
  input wire logic transfer_request,
  input wire logic transfer_ack,
  input wire logic count_pulse,
  input wire logic irq
);
  logic rd_d;
  logic sel_d;
  logic [22:0] addr_d;
  always_ff @(posedge aclk) begin
    rd_d <= !cpu_cs_n && !cpu_iord_n;
    sel_d <= register_select_bit;
    addr_d <= addr_in;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_mem_tail;
    (mem_read && io_write && transfer_ack) ##1 (count_pulse && !mem_read && !io_write);
  endsequence
  sequence s_io_tail;
    (io_read && mem_write && transfer_ack) ##1 (count_pulse && !io_read && !mem_write);
  endsequence
  a_float_unowned: assert property (!hold_ack |-> addr_oe_n && strobe_oe_n)
    else $error("address or strobe drivers on without grant");
  a_oe_joint: assert property (addr_oe_n == strobe_oe_n)
    else $error("address and strobe enables differ");
  a_data_enable: assert property ($past(aresetn) |-> data_oe_n == !rd_d)
    else $error("data enable does not follow the register read");
  a_data_select: assert property ($past(aresetn) && !data_oe_n |->
    (sel_d ? data_out[7:0] == {1'h0, addr_d[22:16]} : data_out == addr_d[15:0]))
    else $error("data pins carry the wrong word");
  a_mem_path: assert property ($rose(mem_read) |-> !io_write ##1 s_mem_tail)
    else $error("memory to device transfer out of order");
  a_io_path: assert property ($rose(io_read) |-> !mem_write ##1 s_io_tail)
    else $error("device to memory transfer out of order");
  a_count_single: assert property (count_pulse |=> !count_pulse)
    else $error("count pulse longer than one cycle");
  a_ack_strobes: assert property (transfer_ack == (mem_read || io_read))
    else $error("transfer acknowledge outside the read strobes");
  a_strobe_owned: assert property ((mem_write || io_write || transfer_ack) |->
    !strobe_oe_n && hold_ack)
    else $error("strobe active without enabled drivers");
  a_grant_first: assert property ($fell(addr_oe_n) |-> hold_request && $past(hold_ack))
    else $error("bus driven before the grant");
  a_request_cause: assert property ($rose(hold_request) |->
    $past(transfer_request) || $past(transfer_request, 2))
    else $error("hold request without a transfer request");
  a_release_wait: assert property (hold_ack && !hold_request |=> !hold_request)
    else $error("new hold request before the grant was removed");
  a_reset_quiet: assert property (disable iff (1'h0) !aresetn |=>
    !hold_request && !transfer_ack && addr_oe_n && data_oe_n && !irq && !count_pulse)
    else $error("outputs active after reset");
endmodule : dcb_checker

// ===== tb_dcb_transfer_controller.sv
// Self-checking bench: AXI4-Lite register traffic, CPU pin reads and DMA transfers.
// Assumes the far-side model answers the hold handshake and keeps the counters.
`timescale 1ns/1ps
module tb_dcb_transfer_controller;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cpu_cs_n = 1'h1, cpu_iord_n = 1'h1, register_select_bit = 1'h0;
  logic [15:0] data_out;
  logic data_oe_n, addr_oe_n, strobe_oe_n, mem_read, mem_write, io_read, io_write;
  logic [22:0] addr_in, addr_out;
  logic hold_request, hold_ack, transfer_request = 1'h0, transfer_ack;
  logic count_pulse, counter_clear, count_zero, irq;
  logic slow = 1'h0, load = 1'h0;
  logic [15:0] load_words = 16'h0;
  int n_mismatch = 0, n_compared = 0, n_cnt = 0, n_iw = 0, n_mw = 0, n_clr = 0;

  always #12.5 aclk = ~aclk;
  dcb_transfer_controller dcb_transfer_controller_i (.*);
  dcb_far_model dcb_far_model_i (.*);

  // Pre-edge values are sampled, so the design's own updates never race these counts.
  always @(posedge aclk) begin
    if (count_pulse === 1'h1) n_cnt++;
    if (io_write === 1'h1) n_iw++;
    if (mem_write === 1'h1) n_mw++;
    if (counter_clear === 1'h1) n_clr++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, got;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    ta = 1'h0;
    tw = 1'h0;
    got = 1'h0;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || (awvalid && awready === 1'h1);
      tw = tw || (wvalid && wready === 1'h1);
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h1;
    while (!got) begin
      @(negedge aclk);
      got = (bvalid === 1'h1);
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic tk, got;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    got = 1'h0;
    while (!got) begin
      @(negedge aclk);
      tk = arvalid && arready === 1'h1;
      got = (rvalid === 1'h1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (tk) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    // Let an edge pass so that a following read never re-raises rready in this step.
    @(posedge aclk);
    chk("rdata", exp, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd

  task automatic pin(input logic sel, input logic [15:0] exp);
    cpu_cs_n <= 1'h0;
    cpu_iord_n <= 1'h0;
    register_select_bit <= sel;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("data_oe_n low", 32'h0, {31'h0, data_oe_n});
    chk("data_out", {16'h0, exp}, {16'h0, data_out});
    @(posedge aclk);
    cpu_cs_n <= 1'h1;
    cpu_iord_n <= 1'h1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("data_oe_n high", 32'h1, {31'h0, data_oe_n});
    @(posedge aclk);
  endtask : pin

  // A single transfer drops the request once acknowledged; otherwise it stays up.
  task automatic run(input logic [15:0] w, input logic single);
    int k;
    logic busy, drop;
    load_words <= w;
    load <= 1'h1;
    @(posedge aclk);
    load <= 1'h0;
    transfer_request <= 1'h1;
    k = 0;
    busy = 1'h1;
    while (k < 400 && busy) begin
      @(negedge aclk);
      busy = (k < 5) || hold_request !== 1'h0 || hold_ack !== 1'h0;
      drop = single && transfer_ack === 1'h1;
      @(posedge aclk);
      if (drop) transfer_request <= 1'h0;
      k++;
    end
    transfer_request <= 1'h0;
  endtask : run

  task automatic zero_counts;
    n_cnt = 0;
    n_iw = 0;
    n_mw = 0;
    n_clr = 0;
  endtask : zero_counts

  task automatic finish_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(dcb_pkg::OFS_CTRL, 32'h0, dcb_pkg::RESP_OKAY);
    rd(dcb_pkg::OFS_INT_MASK, 32'h0, dcb_pkg::RESP_OKAY);
    rd(4'h2, 32'h0, dcb_pkg::RESP_SLVERR);
    wr(4'h2, 32'hFF, dcb_pkg::RESP_SLVERR);
    wr(dcb_pkg::OFS_CTRL, 32'h1A, dcb_pkg::RESP_OKAY);
    pin(1'h0, 16'hFFFE);
    pin(1'h1, 16'h2A00);
    // Burst from memory to device, three words, terminal interrupt enabled.
    wr(dcb_pkg::OFS_INT_MASK, 32'h1, dcb_pkg::RESP_OKAY);
    wr(dcb_pkg::OFS_CTRL, 32'h0B, dcb_pkg::RESP_OKAY);
    zero_counts();
    run(16'h3, 1'h0);
    chk("count pulses", 32'h3, n_cnt);
    chk("io writes", 32'h3, n_iw);
    chk("mem writes", 32'h0, n_mw);
    chk("counter clears", 32'h1, n_clr);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(dcb_pkg::OFS_CTRL, 32'h0A, dcb_pkg::RESP_OKAY);
    rd(dcb_pkg::OFS_INT_STS, 32'h3, dcb_pkg::RESP_OKAY);
    pin(1'h0, 16'h0001);
    pin(1'h1, 16'h0A01);
    wr(dcb_pkg::OFS_INT_MASK, 32'h0, dcb_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(dcb_pkg::OFS_INT_STS, 32'h3, dcb_pkg::RESP_OKAY);
    rd(dcb_pkg::OFS_INT_STS, 32'h0, dcb_pkg::RESP_OKAY);
    // Single transfers from device to memory with a slow grant, interrupt disabled.
    slow <= 1'h1;
    wr(dcb_pkg::OFS_CTRL, 32'h11, dcb_pkg::RESP_OKAY);
    zero_counts();
    run(16'h3, 1'h1);
    chk("single pulses", 32'h1, n_cnt);
    chk("single mem writes", 32'h1, n_mw);
    chk("single io writes", 32'h0, n_iw);
    chk("no clear", 32'h0, n_clr);
    wr(dcb_pkg::OFS_CTRL, 32'h15, dcb_pkg::RESP_OKAY);
    @(posedge aclk);
    chk("clear pulse", 32'h1, n_clr);
    rd(dcb_pkg::OFS_STATUS, 32'h10, dcb_pkg::RESP_OKAY);
    rd(dcb_pkg::OFS_CTRL, 32'h11, dcb_pkg::RESP_OKAY);
    run(16'h1, 1'h1);
    chk("last clear", 32'h2, n_clr);
    rd(dcb_pkg::OFS_CTRL, 32'h10, dcb_pkg::RESP_OKAY);
    rd(dcb_pkg::OFS_INT_STS, 32'h2, dcb_pkg::RESP_OKAY);
    wr(dcb_pkg::OFS_INT_MASK, 32'h1, dcb_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq no terminal", 32'h0, {31'h0, irq});
    wr(dcb_pkg::OFS_INT_MASK, 32'h2, dcb_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq done event", 32'h1, {31'h0, irq});
    finish_test();
  end
endmodule : tb_dcb_transfer_controller

bind dcb_transfer_controller dcb_checker dcb_checker_i (.*);
